// *** logic/cfc_fanout_ctrl.sv ***
// Purpose: Control logic of a 19-pair differential clock fanout buffer.
// Assumes: Logic runs on the reference clock; all pins are synchronous to it.
// Notes: Clock gates are meant to be ANDed with the reference in the output path.
// Functional notes
// - Output enables active low: 0 runs, 1 stops.
// - Enable groups: 0-4, 5-14 single, 15-16, 17-18.
// - First power-good rise samples straps, starts up.
// - Later power-good rises exit power-down without resampling.
// - Power-good low: outputs high-impedance, PLL off.
// - Bypass strap 0 fanout, 1 zero-delay PLL.
// - Three straps form address low bits; eight addresses.
// - Bandwidth select 0 high, 1 low.
// - Frequency select 1 is 100, 0 is 133.33.
// - Byte nine: select bit two, fixed bits 0,1.
// - Frequency select defaults to 1 (100 MHz).
// - Outputs run 1:1 with no programming.
// - Bypass outputs follow reference up to 400 MHz.
// - Enable start and stop within 4-12 clocks.
// - Outputs driven within 300 us after power-down exit.
// - First clock within 1.8 ms of start.
`timescale 1ns/100ps
`include "cfc_map.svh"
module cfc_fanout_ctrl #(
	parameter int DRIVE_CYC = int'(`CFC_T_DRVPD_US * `CFC_CLK_MHZ),
	parameter int STAB_CYC = int'($floor(`CFC_T_STAB_MS * 1000.0 * `CFC_CLK_MHZ)),
	parameter int OE_PIPE = `CFC_OE_PIPE_DEFAULT,
	parameter logic [3:0] ADDR_HI = `CFC_SMB_ADDR_HI
)
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic enable_n_pairs_zero_four,
	input wire logic enable_n_pair_five,
	input wire logic enable_n_pair_six,
	input wire logic enable_n_pair_seven,
	input wire logic enable_n_pair_eight,
	input wire logic enable_n_pair_nine,
	input wire logic enable_n_pair_ten,
	input wire logic enable_n_pair_eleven,
	input wire logic enable_n_pair_twelve,
	input wire logic enable_n_pair_thirteen,
	input wire logic enable_n_pair_fourteen,
	input wire logic enable_n_pairs_fifteen_sixteen,
	input wire logic enable_n_pairs_seventeen_eighteen,
	input wire logic power_good_powerdown_n,
	input wire logic addr0_strap,
	input wire logic addr1_strap,
	input wire logic addr2_bypass_strap,
	input wire logic pll_bandwidth_select_n,
	input wire logic frequency_select,
	input wire logic mgmt_bus_clock,
	input wire logic mgmt_bus_data_in,
	output logic mgmt_bus_data_out,
	output logic mgmt_bus_data_oe,
	output logic [`CFC_NUM_PAIRS-1:0] diff_clock_out,
	output logic diff_clock_out_oe,
	output logic pll_enable,
	output logic pll_high_bandwidth,
	output logic zero_delay_mode,
	output logic freq_is_100m
);
	localparam int TW = $clog2(DRIVE_CYC + 1);

	// Drive-up wait must be at least one clock and fit inside the stabilisation limit.
	if (DRIVE_CYC < 1 || DRIVE_CYC > STAB_CYC)
	begin : gen_bad_drive
		$error("Drive-up count must be at least one and within stabilisation time.");
	end

	typedef struct packed
	{
		logic pgPrev;
		logic pgSeen;
		logic powered;
		logic [TW-1:0] timer;
		logic [2:0] addrStrap;
		logic bwStrapN;
		logic strapLoad;
		logic driveOe;
		logic pllOn;
		logic pllHighBw;
		logic zeroDelay;
		logic freq100;
		cfc_pkg::cfc_smb_state_t st;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic [7:0] offset;
		logic isRead;
		logic nack;
		logic sdaOe;
		logic sclPrev;
		logic sdaPrev;
		logic wrStrobe;
		logic [7:0] wrData;
		logic sdaOut;
	} cfc_ctl_t;

	cfc_ctl_t ctlReg;
	cfc_ctl_t ctlNext;
	cfc_reg_if regBus();
	logic [`CFC_NUM_ENABLES-1:0] enableN;
	logic [`CFC_NUM_ENABLES-1:0] laneGate;
	logic sclRise;
	logic sclFall;
	logic busStart;
	logic busStop;

	// Collect the enable pins, one lane per pin.
	assign enableN = {enable_n_pairs_seventeen_eighteen, enable_n_pairs_fifteen_sixteen,
		enable_n_pair_fourteen, enable_n_pair_thirteen, enable_n_pair_twelve,
		enable_n_pair_eleven, enable_n_pair_ten, enable_n_pair_nine, enable_n_pair_eight,
		enable_n_pair_seven, enable_n_pair_six, enable_n_pair_five,
		enable_n_pairs_zero_four};

	// One delay and gate lane per enable pin; gates stay low until powered.
	for (genvar i = 0; i < `CFC_NUM_ENABLES; i++)
	begin : gen_lane
		cfc_enable_lane #(.LATENCY(OE_PIPE)) u_lane
		(
			.ref_clk(ref_clk),
			.sys_rst(sys_rst),
			.clkEn(clk_en),
			.enableN(enableN[i]),
			.allowed(ctlReg.powered),
			.gate(laneGate[i])
		);
	end

	// Fan the lane gates out to the pairs they control.
	assign diff_clock_out = {{2{laneGate[12]}}, {2{laneGate[11]}}, laneGate[10:1],
		{5{laneGate[0]}}};

	// Register bank holding the frequency select byte.
	cfc_reg_bank u_bank
	(
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clkEn(clk_en),
		.regs(regBus)
	);

	assign regBus.offset = ctlReg.offset;
	assign regBus.wrData = ctlReg.wrData;
	assign regBus.wrStrobe = ctlReg.wrStrobe;
	assign regBus.strapLoad = ctlReg.strapLoad;
	assign regBus.strapFreq = frequency_select;

	// Bus line events seen on the reference clock.
	assign sclRise = !ctlReg.sclPrev && mgmt_bus_clock;
	assign sclFall = ctlReg.sclPrev && !mgmt_bus_clock;
	assign busStart = ctlReg.sclPrev && mgmt_bus_clock && ctlReg.sdaPrev && !mgmt_bus_data_in;
	assign busStop = ctlReg.sclPrev && mgmt_bus_clock && !ctlReg.sdaPrev && mgmt_bus_data_in;

	// Power sequencing, strap capture, mode outputs and the bus slave engine.
	always_comb
	begin
		ctlNext = ctlReg;
		ctlNext.pgPrev = power_good_powerdown_n;
		ctlNext.strapLoad = 1'b0;
		ctlNext.wrStrobe = 1'b0;
		ctlNext.sclPrev = mgmt_bus_clock;
		ctlNext.sdaPrev = mgmt_bus_data_in;
		ctlNext.sdaOut = 1'b0;

		if (!power_good_powerdown_n)
		begin
			ctlNext.powered = 1'b0;
			ctlNext.timer = '0;
		end
		else
		begin
			if (!ctlReg.pgPrev && !ctlReg.pgSeen)
			begin
				ctlNext.pgSeen = 1'b1;
				ctlNext.strapLoad = 1'b1;
				ctlNext.addrStrap = {addr2_bypass_strap, addr1_strap, addr0_strap};
				ctlNext.bwStrapN = pll_bandwidth_select_n;
			end
			// Later rises only restart the drive-up wait; straps stay as captured.
			if (!ctlReg.powered)
			begin
				if (ctlReg.timer == TW'(DRIVE_CYC - 1))
					ctlNext.powered = 1'b1;
				else
					ctlNext.timer = ctlReg.timer + 1'b1;
			end
		end

		// Mode outputs follow the captured straps and the frequency select register; no programming is needed.
		ctlNext.driveOe = ctlNext.powered;
		ctlNext.zeroDelay = ctlNext.addrStrap[2];
		ctlNext.pllOn = ctlNext.powered & ctlNext.addrStrap[2];
		ctlNext.pllHighBw = ~ctlNext.bwStrapN;
		ctlNext.freq100 = regBus.freqSel;

		// Bus slave: start and stop override everything, then bit edges.
		if (busStart)
		begin
			ctlNext.st = cfc_pkg::SMB_ADDR;
			ctlNext.bitCnt = '0;
			ctlNext.sdaOe = 1'b0;
		end
		else if (busStop)
		begin
			ctlNext.st = cfc_pkg::SMB_IDLE;
			ctlNext.sdaOe = 1'b0;
		end
		else if (sclRise)
		begin
			case (ctlReg.st)
				cfc_pkg::SMB_ADDR, cfc_pkg::SMB_CMD, cfc_pkg::SMB_WDATA:
				begin
					ctlNext.shift = {ctlReg.shift[6:0], mgmt_bus_data_in};
					ctlNext.bitCnt = ctlReg.bitCnt + 1'b1;
				end
				cfc_pkg::SMB_ACK_RDATA:
					ctlNext.nack = mgmt_bus_data_in;
				default:
					ctlNext.nack = ctlReg.nack;
			endcase
		end
		else if (sclFall)
		begin
			case (ctlReg.st)
				cfc_pkg::SMB_ADDR:
				begin
					if (ctlReg.bitCnt == `CFC_SMB_BYTE_BITS)
					begin
						if (ctlReg.shift[7:1] == {ADDR_HI, ctlReg.addrStrap})
						begin
							ctlNext.st = cfc_pkg::SMB_ACK_ADDR;
							ctlNext.sdaOe = 1'b1;
							ctlNext.isRead = ctlReg.shift[0];
						end
						else
							ctlNext.st = cfc_pkg::SMB_IDLE;
					end
				end
				cfc_pkg::SMB_CMD:
				begin
					if (ctlReg.bitCnt == `CFC_SMB_BYTE_BITS)
					begin
						ctlNext.offset = ctlReg.shift;
						ctlNext.st = cfc_pkg::SMB_ACK_CMD;
						ctlNext.sdaOe = 1'b1;
					end
				end
				cfc_pkg::SMB_WDATA:
				begin
					if (ctlReg.bitCnt == `CFC_SMB_BYTE_BITS)
					begin
						ctlNext.wrStrobe = 1'b1;
						ctlNext.wrData = ctlReg.shift;
						ctlNext.st = cfc_pkg::SMB_ACK_WDATA;
						ctlNext.sdaOe = 1'b1;
					end
				end
				cfc_pkg::SMB_ACK_ADDR:
				begin
					if (ctlReg.isRead)
					begin
						ctlNext.st = cfc_pkg::SMB_RDATA;
						ctlNext.shift = {regBus.rdData[6:0], 1'b0};
						ctlNext.sdaOe = ~regBus.rdData[7];
						ctlNext.bitCnt = 4'h1;
					end
					else
					begin
						ctlNext.st = cfc_pkg::SMB_CMD;
						ctlNext.sdaOe = 1'b0;
						ctlNext.bitCnt = '0;
					end
				end
				cfc_pkg::SMB_ACK_CMD, cfc_pkg::SMB_ACK_WDATA:
				begin
					// Further data bytes land at the following offsets.
					if (ctlReg.st == cfc_pkg::SMB_ACK_WDATA)
						ctlNext.offset = ctlReg.offset + 1'b1;
					ctlNext.st = cfc_pkg::SMB_WDATA;
					ctlNext.sdaOe = 1'b0;
					ctlNext.bitCnt = '0;
				end
				cfc_pkg::SMB_RDATA:
				begin
					if (ctlReg.bitCnt == `CFC_SMB_BYTE_BITS)
					begin
						ctlNext.st = cfc_pkg::SMB_ACK_RDATA;
						ctlNext.sdaOe = 1'b0;
						ctlNext.offset = ctlReg.offset + 1'b1;
					end
					else
					begin
						ctlNext.sdaOe = ~ctlReg.shift[7];
						ctlNext.shift = {ctlReg.shift[6:0], 1'b0};
						ctlNext.bitCnt = ctlReg.bitCnt + 1'b1;
					end
				end
				cfc_pkg::SMB_ACK_RDATA:
				begin
					if (!ctlReg.nack)
					begin
						ctlNext.st = cfc_pkg::SMB_RDATA;
						ctlNext.shift = {regBus.rdData[6:0], 1'b0};
						ctlNext.sdaOe = ~regBus.rdData[7];
						ctlNext.bitCnt = 4'h1;
					end
					else
						ctlNext.st = cfc_pkg::SMB_IDLE;
				end
				default:
					ctlNext.st = cfc_pkg::SMB_IDLE;
			endcase
		end
	end

	// State register; reset leaves the part powered down and the bus idle.
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			ctlReg <= '0;
			ctlReg.st <= cfc_pkg::SMB_IDLE;
			ctlReg.sclPrev <= 1'b1;
			ctlReg.sdaPrev <= 1'b1;
			ctlReg.freq100 <= `CFC_FREQ_RESET;
			ctlReg.nack <= 1'b1;
		end
		else if (clk_en)
			ctlReg <= ctlNext;
	end

	// Outputs straight from the state register.
	assign mgmt_bus_data_out = ctlReg.sdaOut;
	assign mgmt_bus_data_oe = ctlReg.sdaOe;
	assign diff_clock_out_oe = ctlReg.driveOe;
	assign pll_enable = ctlReg.pllOn;
	assign pll_high_bandwidth = ctlReg.pllHighBw;
	assign zero_delay_mode = ctlReg.zeroDelay;
	assign freq_is_100m = ctlReg.freq100;
endmodule

// *** logic/cfc_map.svh ***
// Purpose: Named offsets, field positions, reset values and timing figures of the fanout control.
// Assumes: Included by bare name from every design file that needs it.
// Notes: Definitions only.
`ifndef CFC_MAP_SVH
`define CFC_MAP_SVH

// Pair and enable counts.
`define CFC_NUM_PAIRS 19
`define CFC_NUM_ENABLES 13

// Output-enable latency window, in reference clocks, and the default pipeline depth.
`define CFC_OE_LAT_MIN 4
`define CFC_OE_LAT_MAX 12
`define CFC_OE_PIPE_DEFAULT 5

// Timing figures in their own units and the logic clock rate.
`define CFC_CLK_MHZ 40
`define CFC_T_DRVPD_US 300
`define CFC_T_STAB_MS 1.8

// Frequency select register and its fields.
`define CFC_REG_FREQ 8'h09
`define CFC_FS_BIT 2
`define CFC_FSB_BIT 1
`define CFC_FSA_BIT 0
`define CFC_FSB_VALUE 1'h0
`define CFC_FSA_VALUE 1'h1
`define CFC_FREQ_RESET 1'h1
`define CFC_REG_ZERO 8'h00

// Management bus framing.
`define CFC_SMB_BYTE_BITS 4'h8
`define CFC_SMB_ADDR_HI 4'h5

`endif

// *** logic/cfc_pkg.sv ***
// Purpose: Shared types of the clock fanout control.
// Assumes: Constants live in cfc_map.svh.
// Notes: Holds the management bus engine states.
package cfc_pkg;

	// Management bus slave states.
	typedef enum logic [3:0]
	{
		SMB_IDLE,
		SMB_ADDR,
		SMB_ACK_ADDR,
		SMB_CMD,
		SMB_ACK_CMD,
		SMB_WDATA,
		SMB_ACK_WDATA,
		SMB_RDATA,
		SMB_ACK_RDATA
	} cfc_smb_state_t;

endpackage

// *** logic/cfc_reg_if.sv ***
// Purpose: Carries register access and strap loading between the control top and the bank.
// Assumes: Single clock domain, ref_clk.
// Notes: Strobes are one-cycle pulses.
`timescale 1ns/100ps
interface cfc_reg_if;
	logic [7:0] offset;
	logic [7:0] wrData;
	logic wrStrobe;
	logic [7:0] rdData;
	logic strapLoad;
	logic strapFreq;
	logic freqSel;

	modport engine
	(
		output offset,
		output wrData,
		output wrStrobe,
		output strapLoad,
		output strapFreq,
		input rdData,
		input freqSel
	);

	modport bank
	(
		input offset,
		input wrData,
		input wrStrobe,
		input strapLoad,
		input strapFreq,
		output rdData,
		output freqSel
	);
endinterface

// *** logic/cfc_enable_lane.sv ***
// Purpose: Delays one active-low output enable and gates it into a whole-cycle clock gate.
// Assumes: Enable pin is synchronous to ref_clk.
// Notes: Gate follows the pin LATENCY plus one clocks later.
`timescale 1ns/100ps
`include "cfc_map.svh"
module cfc_enable_lane #(
	parameter int LATENCY = `CFC_OE_PIPE_DEFAULT
)
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic enableN,
	input wire logic allowed,
	output logic gate
);
	typedef struct packed
	{
		logic [LATENCY-1:0] pipe;
		logic gate;
	} cfc_lane_t;

	cfc_lane_t laneReg;
	cfc_lane_t laneNext;

	// The pipe depth plus the gate stage must land inside the start and stop window.
	if (LATENCY < 2 || LATENCY + 1 < `CFC_OE_LAT_MIN || LATENCY + 1 > `CFC_OE_LAT_MAX)
	begin : gen_bad_latency
		$error("Enable latency outside the allowed window.");
	end

	// Shift the active-high enable through the pipe; the gate only moves on a clock edge.
	always_comb
	begin
		laneNext = laneReg;
		laneNext.pipe = {laneReg.pipe[LATENCY-2:0], ~enableN};
		laneNext.gate = allowed & laneReg.pipe[LATENCY-1];
	end

	// State register with clock enable.
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			laneReg <= '0;
		else if (clkEn)
			laneReg <= laneNext;
	end

	assign gate = laneReg.gate;
endmodule

// *** logic/cfc_reg_bank.sv ***
// Purpose: Frequency select register bank reached over the management bus.
// Assumes: Offsets other than the frequency select byte read as zero and ignore writes.
// Notes: Strap loading and bus writes never coincide in practice; the bus write wins.
`timescale 1ns/100ps
`include "cfc_map.svh"
module cfc_reg_bank
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	cfc_reg_if.bank regs
);
	typedef struct packed
	{
		logic freqSel;
	} cfc_bank_t;

	cfc_bank_t bankReg;
	cfc_bank_t bankNext;

	// Strap load at first power good, then bus writes override the select bit.
	always_comb
	begin
		bankNext = bankReg;
		if (regs.strapLoad)
			bankNext.freqSel = regs.strapFreq;
		if (regs.wrStrobe && regs.offset == `CFC_REG_FREQ)
			bankNext.freqSel = regs.wrData[`CFC_FS_BIT];
	end

	// Power-up default selects the 100 MHz setting.
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			bankReg.freqSel <= `CFC_FREQ_RESET;
		else if (clkEn)
			bankReg <= bankNext;
	end

	// Read mux: the select state plus two fixed select bits.
	always_comb
	begin
		regs.rdData = `CFC_REG_ZERO;
		if (regs.offset == `CFC_REG_FREQ)
		begin
			regs.rdData[`CFC_FS_BIT] = bankReg.freqSel;
			regs.rdData[`CFC_FSB_BIT] = `CFC_FSB_VALUE;
			regs.rdData[`CFC_FSA_BIT] = `CFC_FSA_VALUE;
		end
	end

	assign regs.freqSel = bankReg.freqSel;
endmodule

// *** verification/cfc_fanout_ctrl_props.sv ***
// Purpose: Concurrent checks on the fanout control ports.
// Assumes: Default enable pipeline depth, so a pin change shows after six edges.
// Notes: Bound to every instance of the control top.
`timescale 1ns/100ps
`include "cfc_map.svh"
module cfc_fanout_ctrl_props #(
	parameter int DRIVE_CYC = 20
)
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic enable_n_pair_five,
	input wire logic enable_n_pairs_fifteen_sixteen,
	input wire logic enable_n_pairs_seventeen_eighteen,
	input wire logic power_good_powerdown_n,
	input wire logic [`CFC_NUM_PAIRS-1:0] diff_clock_out,
	input wire logic diff_clock_out_oe,
	input wire logic pll_enable,
	input wire logic pll_high_bandwidth,
	input wire logic zero_delay_mode,
	input wire logic freq_is_100m
);
	logic [31:0] pgCnt_reg;
	logic started_reg;

	// Counts power-good samples and remembers that the outputs have come up once.
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			pgCnt_reg <= '0;
			started_reg <= 1'h0;
		end
		else if (clk_en)
		begin
			pgCnt_reg <= power_good_powerdown_n ? pgCnt_reg + 32'h1 : '0;
			started_reg <= started_reg | diff_clock_out_oe;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// Port relations, each tied to its cause; the enable checks wait eight samples against the six-edge latency.
	property p_pdOff;
		(!power_good_powerdown_n && clk_en)[*3] |-> !diff_clock_out_oe && !pll_enable
			&& diff_clock_out == '0;
	endproperty
	a_pdOff: assert property (p_pdOff)
		else $error("outputs still driven in power-down");
	property p_pllMode;
		diff_clock_out_oe |-> pll_enable == zero_delay_mode;
	endproperty
	a_pllMode: assert property (p_pllMode)
		else $error("PLL state disagrees with mode");
	property p_pairOn;
		(!enable_n_pair_five && diff_clock_out_oe && clk_en)[*8] |-> diff_clock_out[5];
	endproperty
	a_pairOn: assert property (p_pairOn)
		else $error("enabled pair five not running");
	property p_groupOn;
		(!enable_n_pairs_fifteen_sixteen && diff_clock_out_oe && clk_en)[*8]
			|-> diff_clock_out[16:15] == 2'h3;
	endproperty
	a_groupOn: assert property (p_groupOn)
		else $error("group fifteen sixteen not running");
	property p_groupOff;
		(enable_n_pairs_seventeen_eighteen && clk_en)[*8] |-> diff_clock_out[18:17] == 2'h0;
	endproperty
	a_groupOff: assert property (p_groupOff)
		else $error("group seventeen eighteen not stopped");
	property p_driveUp;
		$rose(diff_clock_out_oe) |-> pgCnt_reg == 32'(DRIVE_CYC);
	endproperty
	a_driveUp: assert property (p_driveUp)
		else $error("outputs driven at wrong time");
	property p_freqDefault;
		$fell(sys_rst) |-> freq_is_100m;
	endproperty
	a_freqDefault: assert property (p_freqDefault)
		else $error("frequency select not at default");
	property p_strapsHeld;
		started_reg |-> $stable(zero_delay_mode) && $stable(pll_high_bandwidth);
	endproperty
	a_strapsHeld: assert property (p_strapsHeld)
		else $error("straps taken again");
endmodule

bind cfc_fanout_ctrl cfc_fanout_ctrl_props #(.DRIVE_CYC(DRIVE_CYC)) cfc_fanout_ctrl_props_i (.*);

// *** verification/cfc_smb_host.sv ***
// Purpose: Management bus host on the far side of the fanout control.
// Assumes: Pulled-up data line; reference clock runs during transfers.
// Notes: A third of a bit lasts four reference clocks.
`timescale 1ns/100ps
module cfc_smb_host
(
	input wire logic ref_clk,
	input wire logic devOe,
	output logic busClk,
	output logic busData
);
	logic hostLow;

	// Wire level: either party may pull the line low, the pull-up wins otherwise.
	assign busData = !hostLow && !devOe;

	// Bus idles with clock and data high.
	initial
	begin
		busClk = 1'h1;
		hostLow = 1'h0;
	end

	// Paces the bus from the reference clock, so it is only used while that clock runs.
	task automatic hold();
		repeat (4) @(negedge ref_clk);
	endtask

	// Start or repeated start: data falls while the clock is high.
	task automatic start();
		hostLow = 1'h0;
		hold();
		busClk = 1'h1;
		hold();
		hostLow = 1'h1;
		hold();
		busClk = 1'h0;
		hold();
	endtask

	// Stop: data rises while the clock is high.
	task automatic stop();
		hostLow = 1'h1;
		hold();
		busClk = 1'h1;
		hold();
		hostLow = 1'h0;
		hold();
	endtask

	// Sends nine bits most significant first and returns the line level at each high clock.
	task automatic xfer(input logic [8:0] w, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
		begin
			hostLow = !w[i];
			hold();
			busClk = 1'h1;
			hold();
			r[i] = busData;
			busClk = 1'h0;
			hold();
		end
	endtask
endmodule

// *** verification/tb_clock_fanout_control.sv ***
// Purpose: Self-checking bench of the fanout control.
// Assumes: Drive-up count shortened to twenty clocks.
// Notes: Device address is 0x2D with straps 1,0,1.
`timescale 1ns/100ps
module tb_clock_fanout_control;
	localparam int DRIVE = 20;
	logic refClk = 1'h0;
	logic sysRst, clkEn, powerGood, addr0, addr1, addr2, bwN, freqSel;
	logic [12:0] enN;
	wire logic busClk, busData;
	logic [18:0] diffOut;
	logic dataOut, dataOe, outOe, pllEn, pllHbw, zdm, fs100;
	int badCount = 0;
	int nTests = 0;
	int cyc = 0;

	// Reference clock at 40 MHz.
	always #12.5 refClk = !refClk;

	cfc_fanout_ctrl #(.DRIVE_CYC(DRIVE)) cfc_fanout_ctrl_i (.ref_clk(refClk), .sys_rst(sysRst),
		.clk_en(clkEn), .enable_n_pairs_zero_four(enN[0]), .enable_n_pair_five(enN[1]),
		.enable_n_pair_six(enN[2]), .enable_n_pair_seven(enN[3]), .enable_n_pair_eight(enN[4]),
		.enable_n_pair_nine(enN[5]), .enable_n_pair_ten(enN[6]), .enable_n_pair_eleven(enN[7]),
		.enable_n_pair_twelve(enN[8]), .enable_n_pair_thirteen(enN[9]),
		.enable_n_pair_fourteen(enN[10]), .enable_n_pairs_fifteen_sixteen(enN[11]),
		.enable_n_pairs_seventeen_eighteen(enN[12]), .power_good_powerdown_n(powerGood),
		.addr0_strap(addr0), .addr1_strap(addr1), .addr2_bypass_strap(addr2),
		.pll_bandwidth_select_n(bwN), .frequency_select(freqSel), .mgmt_bus_clock(busClk),
		.mgmt_bus_data_in(busData), .mgmt_bus_data_out(dataOut), .mgmt_bus_data_oe(dataOe),
		.diff_clock_out(diffOut), .diff_clock_out_oe(outOe), .pll_enable(pllEn),
		.pll_high_bandwidth(pllHbw), .zero_delay_mode(zdm), .freq_is_100m(fs100));

	cfc_smb_host cfc_smb_host_i (.ref_clk(refClk), .devOe(dataOe), .busClk(busClk),
		.busData(busData));

	// Prints the counts and the verdict, then ends the run.
	task automatic endOfTest();
		$display("Checks %0d, mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Compares one result and reports a mismatch.
	task automatic check(input logic [18:0] got, input logic [18:0] exp);
		nTests++;
		if (got !== exp)
		begin
			badCount++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Pairs expected to run for a set of active-low enables.
	function automatic logic [18:0] expMask(input logic [12:0] en);
		logic [18:0] m;
		m[4:0] = {5{!en[0]}};
		for (int k = 1; k <= 10; k++)
			m[k + 4] = !en[k];
		m[16:15] = {2{!en[11]}};
		m[18:17] = {2{!en[12]}};
		return m;
	endfunction

	task automatic ticks(input int n);
		repeat (n) @(negedge refClk);
	endtask

	// Raises power good and checks when and how the outputs come up.
	task automatic powerUp();
		powerGood = 1'h1;
		ticks(DRIVE - 1);
		check(outOe, 1'h0);
		ticks(1);
		check(outOe, 1'h1);
		check(pllEn, 1'h1);
		check(zdm, 1'h1);
		check(pllHbw, 1'h1);
		check(fs100, 1'h1);
	endtask

	// Enables each lane alone, then all, checking the latency window.
	task automatic enables();
		logic [12:0] prev;
		prev = 13'h1FFF;
		for (int k = 0; k < 13; k++)
		begin
			enN = ~(13'h1 << k);
			ticks(3);
			check(diffOut, expMask(prev));
			ticks(4);
			check(diffOut, expMask(enN));
			prev = enN;
		end
		enN = '0;
		ticks(7);
		check(diffOut, 19'h7FFFF);
	endtask

	// Powers down, moves the straps, and powers up again.
	task automatic powerDown();
		powerGood = 1'h0;
		ticks(1);
		check(outOe, 1'h0);
		check(pllEn, 1'h0);
		check(diffOut, 19'h7FFFF);
		ticks(1);
		check(diffOut, 19'h0);
		ticks(1);
		addr2 = 1'h0;
		bwN = 1'h1;
		freqSel = 1'h0;
		powerUp();
	endtask

	// Sends one byte and checks the device acknowledge.
	task automatic busByte(input logic [7:0] b, input logic expAck);
		logic [8:0] r;
		cfc_smb_host_i.xfer({b, 1'h1}, r);
		check(r[0], !expAck);
	endtask

	// Reads one register with a repeated start.
	task automatic readReg(input logic [7:0] off, input logic [7:0] exp);
		logic [8:0] r;
		cfc_smb_host_i.start();
		busByte(8'h5A, 1'h1);
		busByte(off, 1'h1);
		cfc_smb_host_i.start();
		busByte(8'h5B, 1'h1);
		cfc_smb_host_i.xfer(9'h1FF, r);
		cfc_smb_host_i.stop();
		check(r[8:1], exp);
	endtask

	// Register reads, a frequency write and a foreign address.
	task automatic smbus();
		readReg(8'h09, 8'h05);
		readReg(8'h03, 8'h00);
		cfc_smb_host_i.start();
		busByte(8'h5A, 1'h1);
		busByte(8'h09, 1'h1);
		busByte(8'h00, 1'h1);
		cfc_smb_host_i.stop();
		check(fs100, 1'h0);
		readReg(8'h09, 8'h01);
		cfc_smb_host_i.start();
		busByte(8'h58, 1'h0);
		cfc_smb_host_i.stop();
		check(dataOut, 1'h0);
	endtask

	// Restarts from reset with the bypass strap low, then freezes the clock enable.
	task automatic bypassMode();
		sysRst = 1'h1;
		powerGood = 1'h0;
		ticks(2);
		sysRst = 1'h0;
		check(fs100, 1'h1);
		check(outOe, 1'h0);
		powerGood = 1'h1;
		ticks(DRIVE - 1);
		check(outOe, 1'h0);
		ticks(1);
		check(outOe, 1'h1);
		check(pllEn, 1'h0);
		check(zdm, 1'h0);
		check(pllHbw, 1'h0);
		check(fs100, 1'h0);
		check(diffOut, 19'h0);
		ticks(1);
		check(diffOut, 19'h7FFFF);
		cfc_smb_host_i.start();
		busByte(8'h52, 1'h1);
		cfc_smb_host_i.stop();
		clkEn = 1'h0;
		enN = 13'h1FFF;
		ticks(8);
		check(diffOut, 19'h7FFFF);
		clkEn = 1'h1;
		ticks(6);
		check(diffOut, 19'h0);
	endtask

	// Cuts a hang short.
	always @(posedge refClk)
	begin
		cyc++;
		if (cyc > 5000)
		begin
			badCount++;
			endOfTest();
		end
	end

	// Main sequence.
	initial
	begin
		sysRst = 1'h1;
		clkEn = 1'h1;
		enN = 13'h1FFF;
		powerGood = 1'h0;
		addr0 = 1'h1;
		addr1 = 1'h0;
		addr2 = 1'h1;
		bwN = 1'h0;
		freqSel = 1'h1;
		ticks(2);
		sysRst = 1'h0;
		check(fs100, 1'h1);
		check({outOe, pllEn}, '0);
		powerUp();
		enables();
		powerDown();
		smbus();
		bypassMode();
		endOfTest();
	end
endmodule
